// file: rtl/cwos_pin_if.sv
// Interface carrying raw pin levels to the synchroniser and clean levels back.
`timescale 1ns/1ps
`default_nettype none
interface cwos_pin_if #(parameter int W = 2);
  logic [W-1:0] raw;   // Levels straight from the pads.
  logic [W-1:0] clean; // Levels after synchronising and agreement.
  modport sync (input raw, output clean);
  modport core (output raw, input clean);
endinterface // cwos_pin_if
`default_nettype wire

// file: rtl/cwos_pkg.sv
// Constants shared by the configuration word decoder and its testbench.
package cwos_pkg;
  // -------------------------------------------------------------------
  // Address map of the special configuration space.
  // -------------------------------------------------------------------
  localparam logic [13:0] CWOS_CFG_ADDR  = 14'h2007; // Setup word location.
  localparam logic [13:0] CWOS_SPACE_LO  = 14'h2000; // First special address.
  localparam logic [13:0] CWOS_SPACE_HI  = 14'h3fff; // Last special address.
  localparam int          CWOS_WORD_W    = 14;       // Width of the setup word.
  localparam int          CWOS_TRIM_W    = 8;        // Width of the oscillator trim.

  // -------------------------------------------------------------------
  // Field positions inside the setup word.
  // -------------------------------------------------------------------
  localparam int CWOS_BG_HI    = 13; // Bandgap trim, upper bit.
  localparam int CWOS_BG_LO    = 12; // Bandgap trim, lower bit.
  localparam int CWOS_DPROT    = 8;  // Data protect, low active.
  localparam int CWOS_PPROT    = 7;  // Program protect, low active.
  localparam int CWOS_BOD_EN   = 6;  // Brown-out detector enable.
  localparam int CWOS_RST_SEL  = 5;  // Shared reset pin role.
  localparam int CWOS_POWERUP_DELAY_TIMER_DIS = 4;  // Power-up delay disable.
  localparam int CWOS_WDT_EN   = 3;  // Watchdog enable.
  localparam int CWOS_OSC_HI   = 2;  // Oscillator select, upper bit.
  localparam int CWOS_OSC_LO   = 0;  // Oscillator select, lower bit.

  // Implemented bits; 11 down to 9 always read as zero.
  localparam logic [13:0] CWOS_IMPL_MASK = 14'h31ff;
  // An unprogrammed word reads all implemented bits as one.
  localparam logic [13:0] CWOS_ERASED    = 14'h31ff;
  localparam logic [7:0]  CWOS_TRIM_RST  = 8'h80; // Trim before first capture.

  // -------------------------------------------------------------------
  // Oscillator select codes.
  // -------------------------------------------------------------------
  typedef enum logic [2:0] {
    CWOS_OSC_LP      = 3'h0, // Low-power crystal.
    CWOS_OSC_XT      = 3'h1, // Standard crystal or resonator.
    CWOS_OSC_HS      = 3'h2, // High-speed crystal or resonator.
    CWOS_OSC_EC      = 3'h3, // External clock in.
    CWOS_OSC_INT_IO  = 3'h4, // Internal oscillator, both pins I/O.
    CWOS_OSC_INT_CLK = 3'h5, // Internal oscillator, divided clock out.
    CWOS_OSC_RC_IO   = 3'h6, // External RC, second pin I/O.
    CWOS_OSC_RC_CLK  = 3'h7  // External RC, divided clock out.
  } cwos_osc_t;

  // Divided clock output: last count of a two-cycle half period (period of four).
  localparam logic [0:0] CWOS_DIV_HALF = 1'h1;
endpackage

// file: rtl/cwos_sync.sv
// Three-stage pin synchroniser; a level is taken once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module cwos_sync #(
  parameter int              W   = 2,
  parameter logic [W-1:0]    RST = '1
) (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clk_en,
  // Pin levels.
  cwos_pin_if.sync  pins
);
  logic [W-1:0] st1; // First stage, read only by the second stage.
  logic [W-1:0] st2; // Second stage.
  logic [W-1:0] st3; // Third stage.
  logic [W-1:0] lvl; // Accepted level.

  // -------------------------------------------------------------------
  // Per-bit pipeline; a change counts only when it has settled.
  // -------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        st1[i] <= RST[i];
        st2[i] <= RST[i];
        st3[i] <= RST[i];
        lvl[i] <= RST[i];
      end else if (clk_en) begin
        st1[i] <= pins.raw[i];
        st2[i] <= st1[i];
        st3[i] <= st2[i];
        // Agreement of two stages filters a single-cycle glitch.
        if (st2[i] == st3[i]) begin
          lvl[i] <= st3[i];
        end
      end
    end
  end

  assign pins.clean = lvl;
endmodule // cwos_sync
`default_nettype wire

// file: rtl/cwos_top.sv
// Setup word store, option decoder and oscillator pin role control.
//
// Overview of operation
// R01: Programmed bit reads zero, unprogrammed reads one.
// R02: Setup word lives at address 2007h.
// R03: Special space reachable only in programming mode.
// R04: Fourteen bits; bits 11 to 9 read zero.
// R05: Top two bits trim the bandgap reference.
// R06: Programmer saves bandgap trim before erasing.
// R07: Bit 8 low protects data memory.
// R08: Bit 7 low protects program memory.
// R09: Clearing data protection erases data EEPROM.
// R10: Clearing program protection erases program and trim.
// R11: Bit 6 enables the brown-out detector.
// R12: Brown-out enable leaves power-up delay alone.
// R13: Bit 5 picks reset pin or I/O.
// R14: Bit 4 high disables power-up delay timer.
// R15: Bit 3 enables the watchdog timer.
// R16: Codes 111/110 select RC, clock-out or I/O.
// R17: Codes 101/100 select internal oscillator modes.
// R18: Code 011 takes clock from input pin.
// R19: Codes 010/001/000 select crystal modes.
// R20: External reset stops internal or RC oscillator.
// R21: Crystal modes also accept an external clock.
// R22: Clock-out pin drives oscillator over four.
// R23: Internal oscillator trim loaded from calibration.
// R24: Capture word in reset, hold until next.
`timescale 1ns/1ps
`default_nettype none
module cwos_top #(
  parameter logic [13:0] NV_INIT = cwos_pkg::CWOS_ERASED // Word after power-on.
) (
  // Clock, reset and freeze.
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic                        clk_en,
  // Programmer port.
  input  wire logic                        prog_mode,
  input  wire logic [13:0]                 prog_addr,
  input  wire logic                        prog_we,
  input  wire logic                        prog_re,
  input  wire logic [13:0]                 prog_wdata,
  output      logic [13:0]                 prog_rdata,
  output      logic                        prog_rvalid,
  // Memory erase requests.
  output      logic                        data_erase,
  output      logic                        program_erase,
  // Core reset state and calibration literal.
  input  wire logic                        core_in_reset,
  input  wire logic [7:0]                  cal_literal,
  // Decoded device options.
  output      logic [1:0]                  bandgap_trim,
  output      logic                        data_protect_n,
  output      logic                        program_protect_n,
  output      logic                        brownout_detect_en,
  output      logic                        ext_reset_pin_sel,
  output      logic                        powerup_delay_dis,
  output      logic                        watchdog_en,
  output      logic [2:0]                  osc_select,
  output      logic [7:0]                  osc_trim_reg,
  // Oscillator mode flags.
  output      logic                        internal_osc_mode,
  output      logic                        resistor_cap_osc_mode,
  output      logic                        ext_clock_in_mode,
  output      logic                        crystal_mode,
  output      logic                        ext_clock_accept,
  // Pins and their roles.
  input  wire logic                        shared_reset_io_i,
  input  wire logic                        osc_pin_in_i,
  input  wire logic                        shared_divided_clock_pin_io_o,
  input  wire logic                        shared_divided_clock_pin_io_oe,
  output      logic                        ext_reset_n,
  output      logic                        osc_stop,
  output      logic                        clock_input_pin,
  output      logic                        clock_input_pin_is_io,
  output      logic                        divided_clock_pin_is_io,
  output      logic                        resonator_en,
  output      logic                        osc_pin_out_o,
  output      logic                        osc_pin_out_oe
);
  import cwos_pkg::*;

  // -------------------------------------------------------------------
  // Storage and state.
  // -------------------------------------------------------------------
  logic [13:0] nv_word;   // Non-volatile setup word as last programmed.
  logic [13:0] cfg_q;     // Word captured at reset; drives all options.
  logic        cfg_hit;   // Programmer addresses the setup word.
  logic        in_space;  // Address lies in the special space.
  logic        wr_word;   // Accepted write to the setup word.
  logic [13:0] next_word; // Word as it will be stored.
  logic        div_cnt;   // Counts oscillator cycles within a half period.
  logic        div_clk;   // Divided clock level.
  cwos_osc_t   mode;      // Captured oscillator selection.
  logic        rst_pin;   // Clean level of the shared reset pin.
  logic        clk_pin;   // Clean level of the clock input pin.

  // Oscillator run control.
  typedef enum logic [1:0] {
    CWOS_RUN  = 2'b01, // Internal or RC oscillator running.
    CWOS_HALT = 2'b10  // Stopped by the external reset.
  } cwos_run_t;
  cwos_run_t run_state;      // Current oscillator state.
  cwos_run_t next_run_state; // Next oscillator state.

  // -------------------------------------------------------------------
  // Pin synchronisers.
  // -------------------------------------------------------------------
  cwos_pin_if #(.W(2)) pin_bus ();

  assign pin_bus.raw = {osc_pin_in_i, shared_reset_io_i};

  cwos_sync #(
    .W   (2),
    .RST (2'h3)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .clk_en (clk_en),
    .pins   (pin_bus)
  );

  assign rst_pin = pin_bus.clean[0];
  assign clk_pin = pin_bus.clean[1];
  assign mode    = cwos_osc_t'(cfg_q[CWOS_OSC_HI:CWOS_OSC_LO]);

  // -------------------------------------------------------------------
  // Programmer access decode.
  // -------------------------------------------------------------------
  // The special space is invisible outside programming mode, so a normal
  // fetch can never see or alter the setup word.
  assign in_space  = prog_mode && (prog_addr >= CWOS_SPACE_LO)
                     && (prog_addr <= CWOS_SPACE_HI); // R03
  assign cfg_hit   = in_space && (prog_addr == CWOS_CFG_ADDR); // R02
  assign wr_word   = cfg_hit && prog_we;
  assign next_word = prog_wdata & CWOS_IMPL_MASK; // R04

  // Store; a programmed bit is kept as zero, an erased bit as one.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      nv_word <= NV_INIT & CWOS_IMPL_MASK; // R01
    end else if (clk_en && wr_word) begin
      nv_word <= next_word; // R04
    end
  end

  // Read path; unmapped special addresses read zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_rdata  <= '0;
      prog_rvalid <= 1'b0;
    end else if (clk_en) begin
      prog_rvalid <= in_space && prog_re; // R03
      if (cfg_hit && prog_re) begin
        prog_rdata <= nv_word & CWOS_IMPL_MASK; // R04
      end else begin
        prog_rdata <= '0;
      end
    end
  end

  // Lifting a protection wipes what it guarded; a pulse per event.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      data_erase    <= 1'b0;
      program_erase <= 1'b0;
    end else if (clk_en) begin
      data_erase    <= wr_word && !nv_word[CWOS_DPROT]
                       && next_word[CWOS_DPROT]; // R09
      program_erase <= wr_word && !nv_word[CWOS_PPROT]
                       && next_word[CWOS_PPROT]; // R10
    end
  end

  // -------------------------------------------------------------------
  // Capture at reset.
  // -------------------------------------------------------------------
  // Options change only while the core is held in reset, so running
  // logic never sees a mode switch underneath it.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q        <= CWOS_ERASED;
      osc_trim_reg <= CWOS_TRIM_RST;
    end else if (clk_en && core_in_reset) begin
      cfg_q <= nv_word; // R24
      // A wiped program also wiped the trim literal; keep mid-scale.
      if (program_erase) begin
        osc_trim_reg <= CWOS_TRIM_RST; // R10
      end else begin
        osc_trim_reg <= cal_literal; // R23
      end
    end
  end

  // -------------------------------------------------------------------
  // Option outputs, registered from the captured word.
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bandgap_trim       <= CWOS_ERASED[CWOS_BG_HI:CWOS_BG_LO];
      data_protect_n     <= 1'b1;
      program_protect_n  <= 1'b1;
      brownout_detect_en <= 1'b1;
      ext_reset_pin_sel  <= 1'b1;
      powerup_delay_dis  <= 1'b1;
      watchdog_en        <= 1'b1;
      osc_select         <= CWOS_OSC_RC_CLK;
    end else if (clk_en) begin
      bandgap_trim       <= cfg_q[CWOS_BG_HI:CWOS_BG_LO]; // R05
      data_protect_n     <= cfg_q[CWOS_DPROT]; // R07
      program_protect_n  <= cfg_q[CWOS_PPROT]; // R08
      brownout_detect_en <= cfg_q[CWOS_BOD_EN]; // R11
      ext_reset_pin_sel  <= cfg_q[CWOS_RST_SEL]; // R13
      // Kept apart from the brown-out bit on purpose.
      powerup_delay_dis  <= cfg_q[CWOS_POWERUP_DELAY_TIMER_DIS]; // R12 R14
      watchdog_en        <= cfg_q[CWOS_WDT_EN]; // R15
      osc_select         <= cfg_q[CWOS_OSC_HI:CWOS_OSC_LO];
    end
  end

  // -------------------------------------------------------------------
  // Oscillator mode and pin roles.
  // -------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      internal_osc_mode     <= 1'b0;
      resistor_cap_osc_mode <= 1'b1;
      ext_clock_in_mode     <= 1'b0;
      crystal_mode          <= 1'b0;
      ext_clock_accept      <= 1'b0;
      clock_input_pin_is_io           <= 1'b0;
      divided_clock_pin_is_io          <= 1'b0;
      resonator_en          <= 1'b0;
    end else if (clk_en) begin
      internal_osc_mode     <= 1'b0;
      resistor_cap_osc_mode <= 1'b0;
      ext_clock_in_mode     <= 1'b0;
      crystal_mode          <= 1'b0;
      ext_clock_accept      <= 1'b0;
      clock_input_pin_is_io           <= 1'b0;
      divided_clock_pin_is_io          <= 1'b0;
      resonator_en          <= 1'b0;
      unique case (mode)
        CWOS_OSC_RC_CLK: begin
          resistor_cap_osc_mode <= 1'b1; // R16
        end
        CWOS_OSC_RC_IO: begin
          resistor_cap_osc_mode <= 1'b1; // R16
          divided_clock_pin_is_io          <= 1'b1;
        end
        CWOS_OSC_INT_CLK: begin
          internal_osc_mode <= 1'b1; // R17
          clock_input_pin_is_io       <= 1'b1;
        end
        CWOS_OSC_INT_IO: begin
          internal_osc_mode <= 1'b1; // R17
          clock_input_pin_is_io       <= 1'b1;
          divided_clock_pin_is_io      <= 1'b1;
        end
        CWOS_OSC_EC: begin
          ext_clock_in_mode <= 1'b1; // R18
          ext_clock_accept  <= 1'b1;
          divided_clock_pin_is_io      <= 1'b1;
        end
        CWOS_OSC_HS, CWOS_OSC_XT, CWOS_OSC_LP: begin
          crystal_mode     <= 1'b1; // R19
          resonator_en     <= 1'b1;
          // A driven clock on the input pin works as well as a crystal.
          ext_clock_accept <= 1'b1; // R21
        end
      endcase
    end
  end

  // Clean clock-input level for the clock tree in EC and crystal modes.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      clock_input_pin <= 1'b0;
    end else if (clk_en) begin
      clock_input_pin <= ext_clock_accept ? clk_pin : 1'b0; // R18 R21
    end
  end

  // -------------------------------------------------------------------
  // External reset and oscillator halt.
  // -------------------------------------------------------------------
  // With the pin as I/O the internal reset is tied inactive.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_reset_n <= 1'b1;
    end else if (clk_en) begin
      ext_reset_n <= cfg_q[CWOS_RST_SEL] ? rst_pin : 1'b1; // R13
    end
  end

  always_comb begin
    next_run_state = run_state;
    if (!ext_reset_n && (internal_osc_mode || resistor_cap_osc_mode)) begin
      next_run_state = CWOS_HALT; // R20
    end else begin
      next_run_state = CWOS_RUN;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_state <= CWOS_RUN;
      osc_stop  <= 1'b0;
    end else if (clk_en) begin
      run_state <= next_run_state;
      osc_stop  <= (next_run_state == CWOS_HALT); // R20
    end
  end

  // -------------------------------------------------------------------
  // Divided clock and second oscillator pin.
  // -------------------------------------------------------------------
  // clk stands for the oscillator; the divider holds while it is halted.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_cnt <= 1'b0;
      div_clk <= 1'b0;
    end else if (clk_en && run_state == CWOS_RUN) begin
      if (div_cnt == CWOS_DIV_HALF) begin
        div_cnt <= 1'b0;
        div_clk <= ~div_clk; // R22
      end else begin
        div_cnt <= div_cnt + 1'b1;
      end
    end
  end

  // Clock-out in CWOS_OSC_RC_CLK and CWOS_OSC_INT_CLK modes, the port logic's I/O value where the pin is I/O, else off.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_pin_out_o  <= 1'b0;
      osc_pin_out_oe <= 1'b0;
    end else if (clk_en) begin
      if (mode == CWOS_OSC_RC_CLK || mode == CWOS_OSC_INT_CLK) begin
        osc_pin_out_o  <= div_clk; // R22
        osc_pin_out_oe <= 1'b1;
      end else if (divided_clock_pin_is_io) begin
        osc_pin_out_o  <= shared_divided_clock_pin_io_o; // R17
        osc_pin_out_oe <= shared_divided_clock_pin_io_oe;
      end else begin
        osc_pin_out_o  <= 1'b0;
        osc_pin_out_oe <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Assertions.
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_unimpl_zero;
    prog_rvalid |-> prog_rdata[11:9] == 3'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("bits 11:9 not zero"); // R04

  property p_space_gate;
    clk_en && prog_re && !prog_mode |=> !prog_rvalid;
  endproperty
  a_space_gate: assert property (p_space_gate) else $error("read outside prog mode"); // R03

  property p_hold_word;
    clk_en && !core_in_reset |=> $stable(cfg_q);
  endproperty
  a_hold_word: assert property (p_hold_word) else $error("options moved out of reset"); // R24

  property p_watchdog;
    clk_en |=> watchdog_en == $past(cfg_q[CWOS_WDT_EN]);
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog enable wrong"); // R15

  property p_independent;
    clk_en |=> powerup_delay_dis == $past(cfg_q[CWOS_POWERUP_DELAY_TIMER_DIS])
               && brownout_detect_en == $past(cfg_q[CWOS_BOD_EN]);
  endproperty
  a_independent: assert property (p_independent) else $error("delay tied to brown-out"); // R12

  property p_reset_io;
    clk_en && !cfg_q[CWOS_RST_SEL] |=> ext_reset_n;
  endproperty
  a_reset_io: assert property (p_reset_io) else $error("reset active as I/O"); // R13

  property p_halt;
    clk_en && !ext_reset_n && (internal_osc_mode || resistor_cap_osc_mode)
      |=> osc_stop;
  endproperty
  a_halt: assert property (p_halt) else $error("oscillator not stopped"); // R20

  property p_data_erase;
    clk_en && wr_word && !nv_word[CWOS_DPROT] && next_word[CWOS_DPROT]
      |=> data_erase ##1 (!data_erase || $past(clk_en) == 1'b0 || $past(wr_word));
  endproperty
  a_data_erase: assert property (p_data_erase) else $error("data erase missing"); // R09

  property p_prog_erase;
    clk_en && wr_word && !nv_word[CWOS_PPROT] && next_word[CWOS_PPROT]
      |=> program_erase;
  endproperty
  a_prog_erase: assert property (p_prog_erase) else $error("program erase missing"); // R10

  c_capture: cover property (clk_en && core_in_reset && nv_word != cfg_q);
  c_erase: cover property (program_erase && data_erase);
  c_halt: cover property ($rose(osc_stop));
  c_divided_clock_pin: cover property (osc_pin_out_oe && $rose(osc_pin_out_o));
endmodule // cwos_top
`default_nettype wire

// file: tb/cwos_pin_model.sv
// Pin-side partner: external reset switch on a pulled-up pad and an external clock.
`timescale 1ns/1ps
`default_nettype none
module cwos_pin_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  // Commands from the bench.
  input  wire logic press_reset,
  input  wire logic run_clock,
  // Pad levels.
  output logic      reset_pad,
  output logic      clock_pad
);
  // The pad is pulled up, so a released switch reads high.
  assign reset_pad = ~press_reset;
  logic [1:0] phase; // Clocks spent in the current half period of the source.
  // The source stands low between bursts rather than holding a stale level.
  // A half period of four clocks lets each level outlast the pin filter.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase     <= 2'h0;
      clock_pad <= 1'b0;
    end else if (run_clock) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        clock_pad <= ~clock_pad;
      end
    end else begin
      phase     <= 2'h0;
      clock_pad <= 1'b0;
    end
  end
endmodule // cwos_pin_model
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the setup word decoder.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cwos_pkg::*;
  // ---------------------------------------------------------------
  // Signals.
  // ---------------------------------------------------------------
  logic        clk, resetn, pm, we, re, cir, press, run, io_o, io_oe, rpad, cpad;
  logic [13:0] addr, wd, rd;
  logic [7:0]  cal, trim;
  logic [1:0]  bg, save;
  logic [2:0]  osel;
  logic        rv, de, pe, dp, pp, brownout_detector, rsel, pwd, wdt, im, rcm, ecm, xm, cio, kio, ren;
  logic        xrn, ostop, po, poe, cip, eca;
  int          bad_count, tests_run, cycles;
  // Partner on the pins.
  cwos_pin_model pin_u (.clk(clk), .resetn(resetn), .press_reset(press), .run_clock(run),
    .reset_pad(rpad), .clock_pad(cpad));
  cwos_top dut_u (.clk(clk), .resetn(resetn), .clk_en(1'b1), .prog_mode(pm), .prog_addr(addr),
    .prog_we(we), .prog_re(re), .prog_wdata(wd), .prog_rdata(rd), .prog_rvalid(rv),
    .data_erase(de), .program_erase(pe), .core_in_reset(cir), .cal_literal(cal),
    .bandgap_trim(bg), .data_protect_n(dp), .program_protect_n(pp),
    .brownout_detect_en(brownout_detector), .ext_reset_pin_sel(rsel), .powerup_delay_dis(pwd),
    .watchdog_en(wdt), .osc_select(osel), .osc_trim_reg(trim), .internal_osc_mode(im),
    .resistor_cap_osc_mode(rcm), .ext_clock_in_mode(ecm), .crystal_mode(xm),
    .ext_clock_accept(eca), .shared_reset_io_i(rpad), .osc_pin_in_i(cpad),
    .shared_divided_clock_pin_io_o(io_o), .shared_divided_clock_pin_io_oe(io_oe), .ext_reset_n(xrn),
    .osc_stop(ostop), .clock_input_pin(cip), .clock_input_pin_is_io(cio), .divided_clock_pin_is_io(kio),
    .resonator_en(ren), .osc_pin_out_o(po), .osc_pin_out_oe(poe));
  // Free-running clock, 50 ns period.
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Compare tasks: words with their valid flag, and flag groups.
  task automatic chk_w(input logic [14:0] g, input logic [14:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: word %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_f(input logic [9:0] g, input logic [9:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: flags %b want %b", $time, g, e);
    end
  endtask
  // Programmer port cycles; strobes last one cycle and results land by the next fall.
  task automatic wr(input logic [13:0] a, input logic [13:0] d);
    @(negedge clk);
    {we, re, addr, wd} = {2'b10, a, d};
    @(negedge clk);
    we = 0;
  endtask
  task automatic rdw(input logic [13:0] a);
    @(negedge clk);
    {we, re, addr} = {2'b01, a};
    @(negedge clk);
    re = 0;
  endtask
  // One capture edge, then two edges for the option outputs to follow.
  task automatic cap;
    @(negedge clk);
    cir = 1;
    @(negedge clk);
    cir = 0;
    repeat (2) @(negedge clk);
  endtask
  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the roughly 120 cycles the run needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      tally_and_finish();
    end
  end
  // Main sequence.
  initial begin
    logic [2:0] c;
    logic a, b;
    logic [7:0] opt;
    {resetn, pm, we, re, cir, press, run, io_o, io_oe, addr, wd, cal} = '0;
    {bad_count, tests_run, cycles} = '0;
    cal = 8'h5a;
    run = 1;
    repeat (4) @(negedge clk);
    resetn = 1;
    pm = 1;
    rdw(CWOS_CFG_ADDR);
    chk_w({rv, rd}, {1'b1, CWOS_ERASED});
    save = rd[13:12];
    pm = 0;
    rdw(CWOS_CFG_ADDR);
    chk_w({rv, rd}, 15'h0000);
    pm = 1;
    rdw(14'h1fff);
    chk_w({rv, rd}, 15'h0000);
    wr(CWOS_CFG_ADDR, {save, 3'h7, 9'h07f});
    chk_f({de, pe}, 10'h000);
    rdw(CWOS_CFG_ADDR);
    chk_w({rv, rd}, {1'b1, save, 3'h0, 9'h07f});
    wr(CWOS_CFG_ADDR, {save, 3'h0, 9'h1ff});
    chk_f({de, pe}, 10'h003);
    // Every oscillator code, with each option bit tied to one code bit or its inverse.
    // The reset switch is held while the pin is I/O, so it must have no effect.
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      opt = {c[1:0], ~c[1], ~c[2], c[0], c[2], c[1], ~c[0]};
      press = (i < 4);
      io_oe = 1;
      io_o = c[1];
      wr(CWOS_CFG_ADDR, {opt[7:6], 3'h0, opt[5:0], c});
      cap;
      chk_f({bg, dp, pp, brownout_detector, rsel, pwd, wdt}, opt);
      chk_f({osel, trim[6:0]}, {c, cal[6:0]});
      chk_f({im, rcm, ecm, xm, ren, cio, kio, eca}, {c[2] & ~c[1], c[2] & c[1], i == 3, i < 3,
        i < 3, i == 4 || i == 5, i == 3 || i == 4 || i == 6, i < 4});
      chk_f({xrn, ostop}, 10'h002);
      if (i == 3 || i == 4 || i == 6) chk_f({poe, po}, {io_oe, io_o});
      if (i < 3) chk_f({poe, po}, 10'h000);
      {a, b} = {cip, po};
      repeat (2) @(negedge clk);
      if (i == 5 || i == 7) chk_f({poe, po}, {1'b1, ~b});
      repeat (2) @(negedge clk);
      chk_f(cip, i < 4 && !a);
    end
    press = 1;
    repeat (8) @(negedge clk);
    chk_f({xrn, ostop}, 10'h001);
    press = 0;
    repeat (8) @(negedge clk);
    wr(CWOS_CFG_ADDR, {save, 3'h0, 9'h1f8});
    repeat (2) @(negedge clk);
    chk_f(osel, 10'h007);
    cap;
    chk_f({osel, bg}, {3'h0, save});
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
